/* mbm_pkg.sv */
// Purpose: shared constants and types for the mailbox and bus-matching block
// Assumes: both ports sampled on the single system clock
// Notes: lane positions count from the most significant lane of a long word
`default_nettype none

package mbm_pkg;

	// data widths
	localparam int unsigned LONG_W = 36;
	localparam int unsigned WORD_W = 18;
	localparam int unsigned BYTE_W = 9;

	// buffer depth in front of the b-to-a memory
	localparam int unsigned BUF_DEPTH = 2;

	// reset values
	localparam logic [35:0] DATA_RST = 36'h0_0000_0000;
	localparam logic MAIL_FULL_N_RST = 1'b1;
	localparam logic [1:0] INDEX_RST = 2'h0;

	// lane masks for each port b width
	localparam logic [35:0] MASK_LONG = 36'hF_FFFF_FFFF;
	localparam logic [35:0] MASK_WORD = 36'h0_0003_FFFF;
	localparam logic [35:0] MASK_BYTE = 36'h0_0000_01FF;

	// index of the last piece of a long word for each width
	localparam logic [1:0] LAST_LONG = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// port b width
	typedef enum logic [1:0] {
		SIZE_LONG = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_BYTE = 2'b10
	} mbm_size_type;

	// configuration caught at the end of master reset
	typedef struct packed {
		mbm_size_type size;
		logic big_first;
		logic done;
	} mbm_cfg_type;

	// one decoded port access
	typedef struct packed {
		logic write;
		logic read;
		logic mail;
	} mbm_access_type;

endpackage

`default_nettype wire

/* mbm_mailbox_bus_matching.sv */
// Purpose: mailbox bypass registers and port b bus matching of a two-way fifo
// Assumes: all port pins are synchronous to clock; fifo memories sit outside
// Notes: a-to-b words arrive on a stream, b-to-a words leave through a buffer
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module mbm_mailbox_bus_matching #(
	parameter int unsigned DATA_W = mbm_pkg::LONG_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// configuration straps and resets
	input wire logic bus_match_select,
	input wire logic size_select,
	input wire logic byte_order_select,
	input wire logic a_to_b_master_reset_n,
	input wire logic b_to_a_master_reset_n,
	input wire logic a_to_b_partial_reset_n,
	// port a
	input wire logic port_a_chip_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mailbox_select,
	input wire logic [DATA_W-1:0] port_a_data_in,
	output logic [DATA_W-1:0] port_a_data_out,
	output logic port_a_data_oe,
	// port b
	input wire logic port_b_chip_select_n,
	input wire logic port_b_write_not_read,
	input wire logic port_b_enable,
	input wire logic port_b_mailbox_select,
	input wire logic [DATA_W-1:0] port_b_data_in,
	output logic [DATA_W-1:0] port_b_data_out,
	output logic port_b_data_oe,
	output logic port_b_full_or_input_ready,
	output logic port_b_output_ready,
	// mail flags
	output logic a_to_b_mail_full_n,
	output logic b_to_a_mail_full_n,
	// long words leaving the a-to-b memory
	input wire logic a2b_word_valid,
	input wire logic [DATA_W-1:0] a2b_word,
	output logic a2b_word_ready,
	// long words entering the b-to-a memory
	output logic b2a_word_valid,
	output logic [DATA_W-1:0] b2a_word,
	input wire logic b2a_word_ready,
	// port a fifo output register contents
	input wire logic [DATA_W-1:0] port_a_fifo_out
);

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	// usable lanes for the selected port b width
	function automatic logic [35:0] lane_mask(input mbm_pkg::mbm_size_type s);
		unique case (s)
			mbm_pkg::SIZE_LONG: lane_mask = mbm_pkg::MASK_LONG;
			mbm_pkg::SIZE_WORD: lane_mask = mbm_pkg::MASK_WORD;
			default: lane_mask = mbm_pkg::MASK_BYTE;
		endcase
	endfunction

	// index of the last piece in a long word
	function automatic logic [1:0] last_index(input mbm_pkg::mbm_size_type s);
		unique case (s)
			mbm_pkg::SIZE_LONG: last_index = mbm_pkg::LAST_LONG;
			mbm_pkg::SIZE_WORD: last_index = mbm_pkg::LAST_WORD;
			default: last_index = mbm_pkg::LAST_BYTE;
		endcase
	endfunction

	// lane position (0 = most significant) for a piece sequence number
	function automatic logic [1:0] lane_pos(input logic [1:0] idx,
		input mbm_pkg::mbm_size_type s, input logic big);
		lane_pos = big ? idx : 2'(last_index(s) - idx);
	endfunction

	// pull one piece out of a long word, low aligned
	function automatic logic [35:0] extract(input logic [35:0] w,
		input logic [1:0] pos, input mbm_pkg::mbm_size_type s);
		extract = mbm_pkg::DATA_RST;
		unique case (s)
			mbm_pkg::SIZE_LONG: extract = w;
			mbm_pkg::SIZE_WORD: extract[17:0] = pos[0] ? w[17:0] : w[35:18];
			default: begin
				unique case (pos)
					2'h0: extract[8:0] = w[35:27];
					2'h1: extract[8:0] = w[26:18];
					2'h2: extract[8:0] = w[17:9];
					2'h3: extract[8:0] = w[8:0];
				endcase
			end
		endcase
	endfunction

	// drop one low-aligned piece into its lane of a long word
	function automatic logic [35:0] insert(input logic [35:0] acc,
		input logic [35:0] p, input logic [1:0] pos, input mbm_pkg::mbm_size_type s);
		insert = acc;
		unique case (s)
			mbm_pkg::SIZE_LONG: insert = p;
			mbm_pkg::SIZE_WORD: begin
				if (pos[0]) begin
					insert[17:0] = p[17:0];
				end else begin
					insert[35:18] = p[17:0];
				end
			end
			default: begin
				unique case (pos)
					2'h0: insert[35:27] = p[8:0];
					2'h1: insert[26:18] = p[8:0];
					2'h2: insert[17:9] = p[8:0];
					2'h3: insert[8:0] = p[8:0];
				endcase
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// access decode

	mbm_pkg::mbm_access_type acc_a; // port a access this cycle
	mbm_pkg::mbm_access_type acc_b; // port b access this cycle
	mbm_pkg::mbm_size_type size_strap; // width decoded from straps

	// an access needs chip select low and enable high
	always_comb begin
		acc_a.write = !port_a_chip_select_n && port_a_enable && port_a_write_not_read;
		acc_a.read = !port_a_chip_select_n && port_a_enable && !port_a_write_not_read;
		acc_a.mail = port_a_mailbox_select;
		acc_b.write = !port_b_chip_select_n && port_b_enable && port_b_write_not_read;
		acc_b.read = !port_b_chip_select_n && port_b_enable && !port_b_write_not_read;
		acc_b.mail = port_b_mailbox_select;
	end

	// width straps decode
	always_comb begin
		if (!bus_match_select) begin
			size_strap = mbm_pkg::SIZE_LONG;
		end else if (!size_select) begin
			size_strap = mbm_pkg::SIZE_WORD;
		end else begin
			size_strap = mbm_pkg::SIZE_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration latched on master reset release

	mbm_pkg::mbm_cfg_type cfg_q; // active width, order and ready
	logic both_mrs_n_q; // both master resets high last cycle
	logic both_mrs_n; // both master resets high now
	logic in_b2a_reset; // b-to-a fifo held in master reset
	logic in_a2b_reset; // a-to-b fifo held in master or partial reset

	assign both_mrs_n = a_to_b_master_reset_n && b_to_a_master_reset_n;
	// the far side toggles both master resets together
	assign in_b2a_reset = !b_to_a_master_reset_n;
	assign in_a2b_reset = !a_to_b_master_reset_n || !a_to_b_partial_reset_n;

	// release edge detector; starts high so reset makes no false edge
	always_ff @(posedge clock) begin
		if (rst) begin
			both_mrs_n_q <= 1'b1;
		end else begin
			both_mrs_n_q <= both_mrs_n;
		end
	end

	// straps are caught on the release, a clocked capture, never at rst
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_q <= '{size: mbm_pkg::SIZE_LONG, big_first: 1'b0, done: 1'b0};
		end else if (!both_mrs_n) begin
			cfg_q.done <= 1'b0;
		end else if (!both_mrs_n_q) begin
			cfg_q.size <= size_strap;
			cfg_q.big_first <= byte_order_select;
			cfg_q.done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mail registers and flags

	logic [35:0] mail_a2b_q; // a_to_b_mail_register
	logic [35:0] mail_b2a_q; // b_to_a_mail_register
	logic mail_a2b_wr; // accepted a-to-b mail write
	logic mail_b2a_wr; // accepted b-to-a mail write

	// a write only lands while the flag is high
	assign mail_a2b_wr = acc_a.write && acc_a.mail && a_to_b_mail_full_n;
	assign mail_b2a_wr = acc_b.write && acc_b.mail && b_to_a_mail_full_n;

	// mail content changes only on accepted writes, never on reads
	always_ff @(posedge clock) begin
		if (rst) begin
			mail_a2b_q <= mbm_pkg::DATA_RST;
			mail_b2a_q <= mbm_pkg::DATA_RST;
		end else begin
			if (mail_a2b_wr) begin
				// low lanes only, no byte reordering
				mail_a2b_q <= port_a_data_in & lane_mask(cfg_q.size);
			end
			if (mail_b2a_wr) begin
				mail_b2a_q <= port_b_data_in & lane_mask(cfg_q.size);
			end
		end
	end

	// flags: a write in the same cycle as the far read wins, so no mail is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			a_to_b_mail_full_n <= mbm_pkg::MAIL_FULL_N_RST;
			b_to_a_mail_full_n <= mbm_pkg::MAIL_FULL_N_RST;
		end else begin
			if (mail_a2b_wr) begin
				a_to_b_mail_full_n <= 1'b0;
			end else if (acc_b.read && acc_b.mail) begin
				a_to_b_mail_full_n <= 1'b1;
			end
			if (mail_b2a_wr) begin
				b_to_a_mail_full_n <= 1'b0;
			end else if (acc_a.read && acc_a.mail) begin
				b_to_a_mail_full_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// a-to-b read splitting

	logic [35:0] hold_q; // long word being split
	logic hold_valid_q; // hold_q has pieces left
	logic [1:0] rd_idx_q; // next piece to present
	logic [35:0] fifo_b_out_q; // port b fifo output register
	logic fifo_b_rd; // accepted port b fifo read
	logic hold_load; // long word taken from the memory

	assign fifo_b_rd = acc_b.read && !acc_b.mail && hold_valid_q && cfg_q.done;
	assign hold_load = a2b_word_valid && a2b_word_ready;

	// only whole long words arrive; the rest waits here
	always_ff @(posedge clock) begin
		if (rst || in_a2b_reset) begin
			hold_q <= mbm_pkg::DATA_RST;
			hold_valid_q <= 1'b0;
			rd_idx_q <= mbm_pkg::INDEX_RST;
		end else if (hold_load) begin
			hold_q <= a2b_word;
			hold_valid_q <= 1'b1;
			rd_idx_q <= mbm_pkg::INDEX_RST;
		end else if (fifo_b_rd) begin
			if (rd_idx_q == last_index(cfg_q.size)) begin
				hold_valid_q <= 1'b0;
				rd_idx_q <= mbm_pkg::INDEX_RST;
			end else begin
				rd_idx_q <= 2'(rd_idx_q + 2'h1);
			end
		end
	end

	// ready mirrors an empty hold register, so a word is never overwritten
	always_ff @(posedge clock) begin
		if (rst || in_a2b_reset) begin
			a2b_word_ready <= 1'b0;
		end else begin
			a2b_word_ready <= !(hold_load || (hold_valid_q && !(fifo_b_rd
				&& rd_idx_q == last_index(cfg_q.size))));
		end
	end

	// output register gets the piece in configured order; upper lanes zero
	always_ff @(posedge clock) begin
		if (rst || in_a2b_reset) begin
			fifo_b_out_q <= mbm_pkg::DATA_RST;
		end else if (fifo_b_rd) begin
			fifo_b_out_q <= extract(hold_q,
				lane_pos(rd_idx_q, cfg_q.size, cfg_q.big_first), cfg_q.size);
		end
	end

	// pieces left to read
	always_ff @(posedge clock) begin
		if (rst) begin
			port_b_output_ready <= 1'b0;
		end else begin
			port_b_output_ready <= hold_valid_q && cfg_q.done && !in_a2b_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// b-to-a write assembly and two-entry buffer

	logic [35:0] asm_q; // partly assembled long word
	logic [1:0] wr_idx_q; // next piece expected
	logic fifo_b_wr; // accepted port b fifo write
	logic asm_done; // this write completes a long word
	logic [35:0] asm_word; // completed long word
	logic [35:0] buf_q [mbm_pkg::BUF_DEPTH]; // buffer, entry 0 is the head
	logic [1:0] buf_cnt_q; // words held
	logic buf_push; // word enters the buffer
	logic buf_pop; // head leaves to memory
	logic [1:0] buf_cnt_d; // next word count

	// writes only while the input ready flag is high
	assign fifo_b_wr = acc_b.write && !acc_b.mail && port_b_full_or_input_ready;
	assign asm_done = wr_idx_q == last_index(cfg_q.size);
	// upper inputs beyond the width are masked out
	assign asm_word = insert(asm_q, port_b_data_in & lane_mask(cfg_q.size),
		lane_pos(wr_idx_q, cfg_q.size, cfg_q.big_first), cfg_q.size);
	assign buf_push = fifo_b_wr && asm_done;
	assign buf_pop = b2a_word_valid && b2a_word_ready;
	assign buf_cnt_d = 2'(buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop});

	// leading pieces gather here; the last one commits the long word
	always_ff @(posedge clock) begin
		if (rst || in_b2a_reset) begin
			asm_q <= mbm_pkg::DATA_RST;
			wr_idx_q <= mbm_pkg::INDEX_RST;
		end else if (fifo_b_wr) begin
			asm_q <= asm_done ? mbm_pkg::DATA_RST : asm_word;
			wr_idx_q <= asm_done ? mbm_pkg::INDEX_RST : 2'(wr_idx_q + 2'h1);
		end
	end

	// shift buffer: head is always entry 0 so the outputs are plain flops
	always_ff @(posedge clock) begin
		if (rst || in_b2a_reset) begin
			buf_q[0] <= mbm_pkg::DATA_RST;
			buf_q[1] <= mbm_pkg::DATA_RST;
			buf_cnt_q <= 2'h0;
		end else begin
			buf_cnt_q <= buf_cnt_d;
			if (buf_pop) begin
				buf_q[0] <= (buf_cnt_q == 2'h2) ? buf_q[1] : asm_word;
				if (buf_push) begin
					buf_q[1] <= asm_word;
				end
			end else if (buf_push) begin
				if (buf_cnt_q == 2'h0) begin
					buf_q[0] <= asm_word;
				end else begin
					buf_q[1] <= asm_word;
				end
			end
		end
	end

	// memory side of the buffer; only whole long words go out
	always_ff @(posedge clock) begin
		if (rst || in_b2a_reset) begin
			b2a_word_valid <= 1'b0;
			b2a_word <= mbm_pkg::DATA_RST;
		end else begin
			b2a_word_valid <= buf_cnt_d != 2'h0;
			if (buf_pop) begin
				b2a_word <= (buf_cnt_q == 2'h2) ? buf_q[1] : asm_word;
			end else if (buf_push && buf_cnt_q == 2'h0) begin
				b2a_word <= asm_word;
			end
		end
	end

	// input ready: config done and room left; a stalled memory drops it
	always_ff @(posedge clock) begin
		if (rst || in_b2a_reset) begin
			port_b_full_or_input_ready <= 1'b0;
		end else begin
			// rises only once width and order are in force
			port_b_full_or_input_ready <= cfg_q.done && both_mrs_n_q
				&& buf_cnt_d < 2'(mbm_pkg::BUF_DEPTH);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data output registers

	// mailbox select picks mail or fifo output; one cycle behind the pins
	always_ff @(posedge clock) begin
		if (rst) begin
			port_a_data_out <= mbm_pkg::DATA_RST;
			port_b_data_out <= mbm_pkg::DATA_RST;
		end else begin
			port_a_data_out <= acc_a.mail ? mail_b2a_q : port_a_fifo_out;
			port_b_data_out <= acc_b.mail ? mail_a2b_q : fifo_b_out_q;
		end
	end

	// outputs drive while the port is selected for reading
	always_ff @(posedge clock) begin
		if (rst) begin
			port_a_data_oe <= 1'b0;
			port_b_data_oe <= 1'b0;
		end else begin
			port_a_data_oe <= !port_a_chip_select_n && !port_a_write_not_read;
			port_b_data_oe <= !port_b_chip_select_n && !port_b_write_not_read;
		end
	end

endmodule

`default_nettype wire

/* mbm_mailbox_bus_matching_checker.sv */
// Purpose: port checks of mail flags, mail lanes and long-word streams
// Assumes: one clock, rst synchronous and active high
// Notes: attached to every instance of the block by the bind at the foot
`default_nettype none
module mbm_checker #(
	parameter int unsigned DATA_W = mbm_pkg::LONG_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// straps
	input wire logic bus_match_select,
	input wire logic size_select,
	// port a requests
	input wire logic port_a_chip_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mailbox_select,
	// port b requests and answers
	input wire logic port_b_chip_select_n,
	input wire logic port_b_write_not_read,
	input wire logic port_b_enable,
	input wire logic port_b_mailbox_select,
	input wire logic [DATA_W-1:0] port_b_data_out,
	input wire logic port_b_full_or_input_ready,
	input wire logic port_b_output_ready,
	// mail flags and memory streams
	input wire logic a_to_b_mail_full_n,
	input wire logic b_to_a_mail_full_n,
	input wire logic a2b_word_valid,
	input wire logic a2b_word_ready,
	input wire logic b2a_word_valid,
	input wire logic [DATA_W-1:0] b2a_word,
	input wire logic b2a_word_ready
);
	logic a_acc; // port a access strobe
	logic b_acc; // port b access strobe
	logic a_mw; // port a mail write attempt
	assign a_acc = !port_a_chip_select_n && port_a_enable;
	assign b_acc = !port_b_chip_select_n && port_b_enable;
	assign a_mw = a_acc && port_a_write_not_read && port_a_mailbox_select;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	property p_mail_a_set;
		a_mw && a_to_b_mail_full_n |=> !a_to_b_mail_full_n;
	endproperty
	a_mail_a_set: assert property (p_mail_a_set)
		else $error("a-to-b mail flag not set by write");
	// a write in the same cycle wins, so it is left out here
	property p_mail_a_clr;
		b_acc && !port_b_write_not_read && port_b_mailbox_select && !a_mw |=> a_to_b_mail_full_n;
	endproperty
	a_mail_a_clr: assert property (p_mail_a_clr)
		else $error("a-to-b mail flag not freed by read");
	property p_mail_b_set;
		b_acc && port_b_write_not_read && port_b_mailbox_select && b_to_a_mail_full_n
			|=> !b_to_a_mail_full_n;
	endproperty
	a_mail_b_set: assert property (p_mail_b_set)
		else $error("b-to-a mail flag not set by write");
	// full flag two back means no write landed, so mail shown must not move
	property p_mail_hold;
		$past(port_b_mailbox_select) && $past(port_b_mailbox_select, 2)
			&& !$past(a_to_b_mail_full_n, 2) |-> $stable(port_b_data_out);
	endproperty
	a_mail_hold: assert property (p_mail_hold)
		else $error("mail shown on port b changed while full");
	property p_upper_lanes;
		$past(port_b_mailbox_select) && port_b_full_or_input_ready && bus_match_select
			|-> (port_b_data_out & ~(size_select ? mbm_pkg::MASK_BYTE : mbm_pkg::MASK_WORD)) == 36'h0;
	endproperty
	a_upper_lanes: assert property (p_upper_lanes)
		else $error("port b mail lanes above width not quiet");
	property p_a2b_ready;
		a2b_word_valid && a2b_word_ready |=> !a2b_word_ready;
	endproperty
	a_a2b_ready: assert property (p_a2b_ready)
		else $error("second word taken while hold register full");
	property p_out_ready;
		a2b_word_valid && a2b_word_ready |-> ##[1:3] port_b_output_ready;
	endproperty
	a_out_ready: assert property (p_out_ready)
		else $error("taken word not offered to port b");
	property p_b2a_hold;
		b2a_word_valid && !b2a_word_ready |=> b2a_word_valid && $stable(b2a_word);
	endproperty
	a_b2a_hold: assert property (p_b2a_hold)
		else $error("stalled long word dropped or changed");
	// main scenarios
	c_mail_refused: cover property (a_mw && !a_to_b_mail_full_n);
	c_buffer_full: cover property (b2a_word_valid && !b2a_word_ready && !port_b_full_or_input_ready);
	c_byte_split: cover property (port_b_output_ready && bus_match_select && size_select);
endmodule
bind mbm_mailbox_bus_matching mbm_checker #(.DATA_W(DATA_W)) mbm_checker_inst (
	.clock, .rst, .bus_match_select, .size_select,
	.port_a_chip_select_n, .port_a_write_not_read, .port_a_enable, .port_a_mailbox_select,
	.port_b_chip_select_n, .port_b_write_not_read, .port_b_enable, .port_b_mailbox_select,
	.port_b_data_out, .port_b_full_or_input_ready, .port_b_output_ready,
	.a_to_b_mail_full_n, .b_to_a_mail_full_n, .a2b_word_valid, .a2b_word_ready,
	.b2a_word_valid, .b2a_word, .b2a_word_ready
);
`default_nettype wire

/* mbm_fifo_model.sv */
// Purpose: stand-in for the two fifo memories beside the block
// Assumes: one clock; the bench loads words to offer and reads words caught
// Notes: ready to the block follows stall one cycle late, like a real memory
`default_nettype none
module mbm_fifo_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// stall request from the bench
	input wire logic stall,
	// a-to-b memory side
	output logic a2b_word_valid,
	output logic [35:0] a2b_word,
	input wire logic a2b_word_ready,
	// b-to-a memory side
	input wire logic b2a_word_valid,
	input wire logic [35:0] b2a_word,
	output logic b2a_word_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] src_q [$]; // long words still to offer
	logic [35:0] got_q [$]; // long words the memory took
	////////////////////////////////////////////////////////////
	// offer whole words in order, each held until taken
	always @(posedge clock) begin
		if (rst) begin
			a2b_word_valid <= 1'b0;
			a2b_word <= 36'h0;
		end else begin
			if (a2b_word_valid && a2b_word_ready) begin
				src_q.delete(0);
			end
			if (src_q.size() > 0) begin
				a2b_word_valid <= 1'b1;
				a2b_word <= src_q[0];
			end else begin
				// released lines never keep the last word
				a2b_word_valid <= 1'b0;
				a2b_word <= ~a2b_word;
			end
		end
	end
	// take whole words unless stalled
	always @(posedge clock) begin
		if (rst) begin
			b2a_word_ready <= 1'b0;
		end else begin
			if (b2a_word_valid && b2a_word_ready) begin
				got_q.push_back(b2a_word);
			end
			b2a_word_ready <= !stall;
		end
	end
endmodule
`default_nettype wire

/* test_mbm_mailbox_bus_matching.sv */
// Purpose: self-checking bench for mail, width matching and word streams
// Assumes: both ports on the one clock; memories played by the model
// Notes: each access is one request cycle, then the strobes drop
`default_nettype none
module test_mbm_mailbox_bus_matching;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0; // 250 MHz system clock
	logic rst = 1'b1; // synchronous reset
	logic bus_match_select = 1'b0; // straps, moved only inside master reset
	logic size_select = 1'b0;
	logic byte_order_select = 1'b0;
	logic mrst_n = 1'b1; // both master resets move together
	logic part_n = 1'b1; // partial reset stays high
	logic stall = 1'b0; // memory refuses words while high
	logic [1:0] cs_n = 2'h3; // per port, index 0 is port a
	logic [1:0] wnr = 2'h0;
	logic [1:0] en = 2'h0;
	logic [1:0] mbs = 2'h0;
	logic [35:0] din [2] = '{36'h0, 36'h0};
	logic [35:0] a_fifo = 36'h3_3333_3333; // port a fifo register stand-in
	logic [35:0] port_a_data_out, port_b_data_out, a2b_word, b2a_word, rd, d, mask;
	logic port_a_data_oe, port_b_data_oe, port_b_full_or_input_ready, port_b_output_ready;
	logic a_to_b_mail_full_n, b_to_a_mail_full_n;
	logic a2b_word_valid, a2b_word_ready, b2a_word_valid, b2a_word_ready;
	int failures = 0, total_checks = 0, cycles = 0, i, j, k, n, w;
	mbm_mailbox_bus_matching mbm_mailbox_bus_matching_inst (
		.clock, .rst, .bus_match_select, .size_select, .byte_order_select,
		.a_to_b_master_reset_n(mrst_n), .b_to_a_master_reset_n(mrst_n),
		.a_to_b_partial_reset_n(part_n),
		.port_a_chip_select_n(cs_n[0]), .port_a_write_not_read(wnr[0]),
		.port_a_enable(en[0]), .port_a_mailbox_select(mbs[0]), .port_a_data_in(din[0]),
		.port_a_data_out, .port_a_data_oe,
		.port_b_chip_select_n(cs_n[1]), .port_b_write_not_read(wnr[1]),
		.port_b_enable(en[1]), .port_b_mailbox_select(mbs[1]), .port_b_data_in(din[1]),
		.port_b_data_out, .port_b_data_oe, .port_b_full_or_input_ready, .port_b_output_ready,
		.a_to_b_mail_full_n, .b_to_a_mail_full_n, .a2b_word_valid, .a2b_word, .a2b_word_ready,
		.b2a_word_valid, .b2a_word, .b2a_word_ready, .port_a_fifo_out(a_fifo)
	);
	mbm_fifo_model mbm_fifo_model_inst (
		.clock, .rst, .stall, .a2b_word_valid, .a2b_word, .a2b_word_ready,
		.b2a_word_valid, .b2a_word, .b2a_word_ready
	);
	////////////////////////////////////////////////////////////
	// clock and hang guard
	always #2 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic chk_data(input logic [35:0] exp, input logic [35:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected data at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one request cycle on port p; rd holds what the port shows after it
	task automatic acc(input int p, input logic wr, input logic m, input logic [35:0] v);
		@(posedge clock);
		{cs_n[p], en[p], wnr[p], mbs[p], din[p]} <= {1'b0, 1'b1, wr, m, v};
		@(posedge clock);
		{cs_n[p], en[p], mbs[p]} <= 3'h4;
		#1;
		rd = p ? port_b_data_out : port_a_data_out;
	endtask
	// bounded wait for input ready (0) or output ready (1)
	task automatic wait_hi(input int s);
		int c;
		for (c = 0; c < 64 && (s ? port_b_output_ready : port_b_full_or_input_ready) !== 1'b1; c++)
			@(posedge clock);
	endtask
	task automatic mreset(input logic b, input logic s, input logic e);
		@(posedge clock);
		{bus_match_select, size_select, byte_order_select, mrst_n} <= {b, s, e, 1'b0};
		repeat (3) @(posedge clock);
		mrst_n <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk_flag(port_b_full_or_input_ready, 1'b1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		mreset(1'b0, 1'b0, 1'b0);
		// mail one way: second write refused while port b watches the mail
		acc(0, 1'b1, 1'b1, 36'hA_BCDE_F012);
		chk_flag(a_to_b_mail_full_n, 1'b0);
		@(posedge clock);
		mbs[1] <= 1'b1;
		acc(0, 1'b1, 1'b1, 36'h5_5555_5555);
		chk_data(36'hA_BCDE_F012, port_b_data_out);
		acc(1, 1'b0, 1'b1, 36'h0);
		chk_data(36'hA_BCDE_F012, rd);
		chk_flag(a_to_b_mail_full_n, 1'b1);
		chk_flag(port_b_data_oe, 1'b1);
		acc(1, 1'b0, 1'b1, 36'h0);
		chk_data(36'hA_BCDE_F012, rd);
		// mail the other way, then a plain fifo read on port a
		acc(1, 1'b1, 1'b1, 36'h1_2345_6789);
		chk_flag(b_to_a_mail_full_n, 1'b0);
		chk_flag(port_b_data_oe, 1'b0);
		acc(0, 1'b0, 1'b1, 36'h0);
		chk_data(36'h1_2345_6789, rd);
		chk_flag(b_to_a_mail_full_n, 1'b1);
		chk_flag(port_a_data_oe, 1'b1);
		acc(0, 1'b0, 1'b0, 36'h0);
		chk_data(a_fifo, rd);
		// fill the two-entry buffer against a stalled memory, then drain
		@(posedge clock);
		stall <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		for (i = 0; i < 4 && port_b_full_or_input_ready === 1'b1; i++) begin
			acc(1, 1'b1, 1'b0, 36'hC_0000_0000 + i);
			@(posedge clock);
			#1;
		end
		chk_data(36'h2, 36'(i));
		acc(1, 1'b1, 1'b0, 36'hD_DDDD_DDDD); // refused while full
		@(posedge clock);
		stall <= 1'b0;
		repeat (8) @(posedge clock);
		chk_data(36'h2, 36'(mbm_fifo_model_inst.got_q.size()));
		for (i = 0; i < 2; i++)
			chk_data(36'hC_0000_0000 + i, mbm_fifo_model_inst.got_q[i]);
		mbm_fifo_model_inst.got_q.delete();
		// every width and order: long, word big/little, byte big/little
		for (k = 0; k < 5; k++) begin
			n = (k == 0) ? 1 : (k < 3) ? 2 : 4;
			w = 36 / n;
			mask = ~(36'hF_FFFF_FFFF << w);
			mreset(k > 0, k > 2, k[0]);
			acc(0, 1'b1, 1'b1, 36'hF_EDCB_A987);
			acc(1, 1'b0, 1'b1, 36'h0);
			chk_data(36'hF_EDCB_A987 & mask, rd);
			acc(1, 1'b1, 1'b1, 36'h9_8765_4321);
			acc(0, 1'b0, 1'b1, 36'h0);
			chk_data(36'h9_8765_4321 & mask, rd);
			mbm_fifo_model_inst.src_q.push_back(36'h1_2345_6789);
			for (i = 0; i < n; i++) begin
				j = k[0] ? i : n - 1 - i;
				wait_hi(1);
				acc(1, 1'b0, 1'b0, 36'h0);
				@(posedge clock);
				#1;
				d = (36'h1_2345_6789 >> (w * (n - 1 - j))) & mask;
				chk_data(d, port_b_data_out);
			end
			chk_flag(port_b_output_ready, 1'b0);
			for (i = 0; i < n; i++) begin
				j = k[0] ? i : n - 1 - i;
				d = ((36'h2_468A_CE13 >> (w * (n - 1 - j))) & mask) | ~mask;
				wait_hi(0);
				acc(1, 1'b1, 1'b0, d);
			end
			repeat (4) @(posedge clock);
			chk_data(36'h2_468A_CE13, mbm_fifo_model_inst.got_q.pop_front());
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
